// ===== osc_switch_defs.svh
`ifndef OSC_SWITCH_DEFS_SVH
`define OSC_SWITCH_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 5'h00
`define OFS_UNLOCK 5'h04
`define OFS_IRQ_STAT 5'h08
`define OFS_IRQ_CLR 5'h0C
`define OFS_IRQ_EN 5'h10

// ----------------------------------------------------------------
// oscillator_control field positions and reset values
// ----------------------------------------------------------------
`define CTRL_CURRENT_SOURCE_STATUS_MSB 14
`define CTRL_CURRENT_SOURCE_STATUS_LSB 12
`define CTRL_NEW_SOURCE_SELECT_MSB 10
`define CTRL_NEW_SOURCE_SELECT_LSB 8
`define CTRL_LOCK_BIT 5
`define CTRL_CF_BIT 3
`define CTRL_SECONDARY_OSC_ENABLE_BIT 1
`define CTRL_SWITCH_REQUEST_BIT_BIT 0
`define CTRL_SRC_RESET 3'h0
`define IRQ_RESET 3'h0

// ----------------------------------------------------------------
// unlock keys, written in this order to the unlock register
// ----------------------------------------------------------------
`define UNLOCK_KEY1 8'h9A
`define UNLOCK_KEY2 8'h65

// ----------------------------------------------------------------
// source codes, primary submodes, oscillator enable indices
// ----------------------------------------------------------------
`define SRC_FRC 3'h0
`define SRC_FRC_PLL 3'h1
`define SRC_PRI 3'h2
`define SRC_PRI_PLL 3'h3
`define SRC_SEC 3'h4
`define SRC_LOW_POWER_RC_OSC 3'h5
`define SUB_EC 2'h0
`define SUB_XT 2'h1
`define SUB_HS 2'h2
`define OSC_IDX_PRI 0
`define OSC_IDX_SEC 1
`define OSC_IDX_FRC 2
`define OSC_IDX_LOW_POWER_RC_OSC 3

// ----------------------------------------------------------------
// timing and interrupt bits
// ----------------------------------------------------------------
`define SETTLE_EDGES 4'hA
`define INIT_SETTLE 2'h2
`define IRQ_DONE 0
`define IRQ_ABORT 1
`define IRQ_FAIL 2

`endif

// ===== osc_switch_pkg.sv
package osc_switch_pkg;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_CHECK = 5'h02,
		ST_WAIT = 5'h04,
		ST_COUNT = 5'h08,
		ST_SWAP = 5'h10
	} fsm_t;

	typedef logic [2:0] src_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [4:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} avs_req_t;

	typedef struct packed {
		logic fuse_dis;
		src_t init_src;
		logic [1:0] submode;
		logic oscillator_startup_timer;
		logic lock;
		logic new_clk;
		logic fail;
	} pin_sync_t;

	typedef struct packed {
		pin_sync_t s1;
		pin_sync_t s2;
		logic clk_d;
		logic fail_d;
		logic [1:0] init_cnt;
		logic init_done;
		fsm_t fsm;
		logic ack;
		logic [31:0] rdata;
		logic key1_seen;
		logic win_open;
		src_t current_source_status;
		src_t new_source_select;
		src_t target;
		logic secondary_osc_enable;
		logic switch_request_bit;
		logic lock;
		logic cf;
		logic [3:0] edge_cnt;
		logic [2:0] irq_stat;
		logic [2:0] irq_en;
		logic [3:0] osc_en;
		logic pll_en;
		src_t clk_sel;
	} state_t;

endpackage : osc_switch_pkg

// ===== system_clock_switch_controller.sv
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`include "osc_switch_defs.svh"
// Function
// [R1] switching and fail-safe monitor work only when the enable fuse holds 0
// [R2] when disabled, new-source field is ignored; status shows the initial-source fuse
// [R3] when disabled, switch-request writes do nothing and the bit reads 0
// [R4] software unlocks, writes new-source in upper byte, unlocks, sets request low byte
// [R5] request with new-source equal to current source clears request and aborts
// [R6] a valid switch start clears lock status and clock-fail flag
// [R7] target oscillator is started; crystal targets wait for start-up timer
// [R8] multiplier targets wait until multiplier lock is reported
// [R9] ten target clock edges pass before the system clock moves
// [R10] on completion the request clears and new-source copies into current source
// [R11] old source stops, except low-power RC for watchdog/monitor and enabled secondary
// [R12] software must route between the two multiplier modes through plain fast RC
// [R13] primary submode comes only from its fuse field, never from software
// [R14] control register resets only on power-on reset
// [R15] control bit 1 enables the secondary low-power oscillator
// [R16] control bit 0 requests a switch and reads 0 once it completes
// [R17] any of six sources may be chosen at any time through the unlock guard
// [R18] the bus keeps serving software throughout a switch
// [R19] each unlock opens one byte write; other control writes are ignored
module system_clock_switch_controller (
	input wire logic mclk_i, // system clock, 10 MHz
	input wire logic rst_i, // power-on reset, async, active high
	input wire logic soft_rst_i, // any other reset cause, sync
	input wire osc_switch_pkg::avs_req_t avs_i, // avalon request group
	output logic [31:0] avs_readdata_o, // avalon read data
	output logic avs_waitrequest_o, // avalon wait request
	input wire logic clock_switch_enable_fuse_i, // 0 enables switching
	input wire logic [2:0] initial_source_fuse_i, // source after power-on
	input wire logic [1:0] primary_submode_fuse_i, // primary submode
	input wire logic watchdog_enable_i, // watchdog needs low-power rc
	input wire logic ost_expired_i, // start-up timer expired
	input wire logic pll_lock_i, // multiplier lock detect
	input wire logic target_clk_i, // raw clock of the sources
	input wire logic clock_fail_i, // fail-safe monitor fail level
	output logic [3:0] osc_enable_o, // pri, sec, frc, low_power_rc_osc enables
	output logic multiplier_enable_o, // multiplier power
	output logic [2:0] sys_clk_select_o, // source driving system clock
	output logic [1:0] primary_submode_o, // submode to primary pad logic
	output logic switch_busy_o, // switch sequence running
	output logic irq_o // level interrupt
);

	osc_switch_pkg::state_t st;
	osc_switch_pkg::state_t n;
	osc_switch_pkg::pin_sync_t pins_now;
	logic sw_en;
	logic keep_low_power_rc_osc;
	logic req;
	logic acc;
	logic clk_rise;
	logic [2:0] irq_ev;
	logic [2:0] irq_clr;
	logic [15:0] ctrl_view;
	logic [31:0] rd_mux;
	osc_switch_pkg::src_t current_source_status_view;

	// ----------------------------------------------------------------
	// source helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] src_mask(input logic [2:0] s);
		logic [3:0] m;
		m = 4'h0;
		case (s)
			`SRC_PRI, `SRC_PRI_PLL: m[`OSC_IDX_PRI] = 1'b1;
			`SRC_SEC: m[`OSC_IDX_SEC] = 1'b1;
			`SRC_LOW_POWER_RC_OSC: m[`OSC_IDX_LOW_POWER_RC_OSC] = 1'b1;
			default: m[`OSC_IDX_FRC] = 1'b1;
		endcase
		return m;
	endfunction : src_mask

	function automatic logic uses_pll(input logic [2:0] s);
		return (s == `SRC_FRC_PLL) || (s == `SRC_PRI_PLL);
	endfunction : uses_pll

	function automatic logic is_crystal(input logic [2:0] s, input logic [1:0] sub);
		logic pri;
		pri = (s == `SRC_PRI) || (s == `SRC_PRI_PLL);
		return (s == `SRC_SEC) || (pri && (sub == `SUB_XT || sub == `SUB_HS));
	endfunction : is_crystal

	// ----------------------------------------------------------------
	// combinational views
	// ----------------------------------------------------------------
	assign pins_now = '{fuse_dis: clock_switch_enable_fuse_i,
		init_src: initial_source_fuse_i,
		submode: primary_submode_fuse_i,
		oscillator_startup_timer: ost_expired_i,
		lock: pll_lock_i,
		new_clk: target_clk_i,
		fail: clock_fail_i};

	assign sw_en = ~st.s2.fuse_dis; // R1
	// fail-safe monitor lives with switching, so either keeps low_power_rc_osc alive
	assign keep_low_power_rc_osc = watchdog_enable_i | sw_en; // R11
	assign current_source_status_view = sw_en ? st.current_source_status : st.s2.init_src; // R2
	assign clk_rise = st.s2.new_clk & ~st.clk_d;
	assign req = avs_i.read | avs_i.write;
	assign acc = req & st.ack;

	always_comb begin
		ctrl_view = 16'h0000;
		ctrl_view[`CTRL_CURRENT_SOURCE_STATUS_MSB:`CTRL_CURRENT_SOURCE_STATUS_LSB] = current_source_status_view;
		ctrl_view[`CTRL_NEW_SOURCE_SELECT_MSB:`CTRL_NEW_SOURCE_SELECT_LSB] = st.new_source_select;
		ctrl_view[`CTRL_LOCK_BIT] = st.lock;
		ctrl_view[`CTRL_CF_BIT] = st.cf;
		ctrl_view[`CTRL_SECONDARY_OSC_ENABLE_BIT] = st.secondary_osc_enable;
		ctrl_view[`CTRL_SWITCH_REQUEST_BIT_BIT] = st.switch_request_bit & sw_en; // R3
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (avs_i.address)
			`OFS_CTRL: rd_mux[15:0] = ctrl_view;
			`OFS_IRQ_STAT: rd_mux[2:0] = st.irq_stat;
			`OFS_IRQ_EN: rd_mux[2:0] = st.irq_en;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		n = st;
		irq_ev = 3'h0;
		irq_clr = 3'h0;
		n.s1 = pins_now;
		n.s2 = st.s1;
		n.clk_d = st.s2.new_clk;
		n.fail_d = st.s2.fail;

		// the fuse straps settle through the synchroniser before being trusted
		if (!st.init_done) begin
			n.init_cnt = st.init_cnt + 2'h1;
			if (st.init_cnt == `INIT_SETTLE) begin
				n.init_done = 1'b1;
				n.current_source_status = st.s2.init_src;
				n.new_source_select = st.s2.init_src;
			end
		end

		// one wait state; read data is latched while waitrequest is high
		n.ack = req & ~st.ack;
		if (req && !st.ack) begin
			n.rdata = rd_mux;
		end

		if (acc && avs_i.write) begin // R18
			unique case (avs_i.address)
				`OFS_CTRL: begin
					if (st.win_open) begin // R19
						if (avs_i.byteenable[1]) begin
							n.new_source_select = avs_i.writedata[`CTRL_NEW_SOURCE_SELECT_MSB:`CTRL_NEW_SOURCE_SELECT_LSB]; // R4
						end else if (avs_i.byteenable[0]) begin
							n.secondary_osc_enable = avs_i.writedata[`CTRL_SECONDARY_OSC_ENABLE_BIT]; // R15
							// a cleared request bit cannot cancel a running switch
							if (avs_i.writedata[`CTRL_SWITCH_REQUEST_BIT_BIT] && sw_en) begin // R3
								n.switch_request_bit = 1'b1; // R16
							end
						end
					end
					n.win_open = 1'b0; // R19
					n.key1_seen = 1'b0;
				end
				`OFS_UNLOCK: begin
					if (avs_i.byteenable[0]) begin // R17
						n.key1_seen = (avs_i.writedata[7:0] == `UNLOCK_KEY1);
						n.win_open = st.key1_seen && (avs_i.writedata[7:0] == `UNLOCK_KEY2);
					end
				end
				`OFS_IRQ_CLR: irq_clr = avs_i.writedata[2:0];
				`OFS_IRQ_EN: n.irq_en = avs_i.writedata[2:0];
				default: n.win_open = st.win_open;
			endcase
		end

		if (st.s2.lock && st.pll_en) begin
			n.lock = 1'b1;
		end else if (!st.pll_en) begin
			n.lock = 1'b0;
		end

		unique case (st.fsm)
			osc_switch_pkg::ST_IDLE: begin
				if (st.switch_request_bit && sw_en && st.init_done) begin
					n.fsm = osc_switch_pkg::ST_CHECK;
				end
			end
			osc_switch_pkg::ST_CHECK: begin
				if (st.new_source_select == st.current_source_status) begin // R5
					n.switch_request_bit = 1'b0;
					irq_ev[`IRQ_ABORT] = 1'b1;
					n.fsm = osc_switch_pkg::ST_IDLE;
				end else begin
					n.lock = 1'b0; // R6
					n.cf = 1'b0; // R6
					n.target = st.new_source_select;
					n.edge_cnt = 4'h0;
					n.fsm = osc_switch_pkg::ST_WAIT;
				end
			end
			osc_switch_pkg::ST_WAIT: begin
				if ((!is_crystal(st.target, st.s2.submode) || st.s2.oscillator_startup_timer) && // R7
					(!uses_pll(st.target) || st.lock)) begin // R8
					n.fsm = osc_switch_pkg::ST_COUNT;
				end
			end
			osc_switch_pkg::ST_COUNT: begin
				if (clk_rise) begin
					n.edge_cnt = st.edge_cnt + 4'h1; // R9
					if (st.edge_cnt == `SETTLE_EDGES - 4'h1) begin
						n.fsm = osc_switch_pkg::ST_SWAP;
					end
				end
			end
			osc_switch_pkg::ST_SWAP: begin
				n.current_source_status = st.target; // R10
				n.switch_request_bit = 1'b0; // R16
				irq_ev[`IRQ_DONE] = 1'b1;
				n.fsm = osc_switch_pkg::ST_IDLE;
			end
		endcase

		// a fresh failure wins over the start-of-switch clear
		if (st.s2.fail && !st.fail_d && sw_en) begin
			n.cf = 1'b1;
			irq_ev[`IRQ_FAIL] = 1'b1;
		end
		if (!sw_en) begin
			n.switch_request_bit = 1'b0; // R3
		end

		n.irq_stat = (st.irq_stat & ~irq_clr) | irq_ev;

		// ----------------------------------------------------------------
		// oscillator power; the submode is never touched by software
		// ----------------------------------------------------------------
		n.clk_sel = sw_en ? n.current_source_status : st.s2.init_src; // R2
		n.osc_en = src_mask(n.clk_sel); // R11
		n.pll_en = uses_pll(n.clk_sel);
		if (n.fsm != osc_switch_pkg::ST_IDLE && n.fsm != osc_switch_pkg::ST_CHECK) begin
			n.osc_en = n.osc_en | src_mask(n.target); // R7
			n.pll_en = n.pll_en | uses_pll(n.target);
		end
		if (n.secondary_osc_enable) begin
			n.osc_en[`OSC_IDX_SEC] = 1'b1; // R11
		end
		if (keep_low_power_rc_osc) begin
			n.osc_en[`OSC_IDX_LOW_POWER_RC_OSC] = 1'b1; // R11
		end

		// other resets spare the control register contents
		if (soft_rst_i) begin // R14
			n.fsm = osc_switch_pkg::ST_IDLE;
			n.ack = 1'b0;
			n.rdata = 32'h0000_0000;
			n.key1_seen = 1'b0;
			n.win_open = 1'b0;
			n.edge_cnt = 4'h0;
			n.irq_stat = `IRQ_RESET;
			n.irq_en = `IRQ_RESET;
		end
	end

	// ----------------------------------------------------------------
	// state register, cleared in full only by power-on reset
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin // R14
			st <= '0;
			st.fsm <= osc_switch_pkg::ST_IDLE;
			st.current_source_status <= `CTRL_SRC_RESET;
			st.new_source_select <= `CTRL_SRC_RESET;
			st.target <= `CTRL_SRC_RESET;
			st.clk_sel <= `CTRL_SRC_RESET;
			st.osc_en <= 4'h4;
		end else begin
			st <= n;
		end
	end

	assign avs_readdata_o = st.rdata;
	assign avs_waitrequest_o = req & ~st.ack;
	assign osc_enable_o = st.osc_en;
	assign multiplier_enable_o = st.pll_en;
	assign sys_clk_select_o = st.clk_sel;
	assign primary_submode_o = st.s2.submode; // R13
	assign switch_busy_o = (st.fsm != osc_switch_pkg::ST_IDLE);
	assign irq_o = |(st.irq_stat & st.irq_en);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);

	sequence seq_valid_start;
		st.fsm == osc_switch_pkg::ST_CHECK && st.new_source_select != st.current_source_status && !soft_rst_i;
	endsequence

	sequence seq_swap;
		st.fsm == osc_switch_pkg::ST_SWAP && !soft_rst_i;
	endsequence

	// the target keeps its power for the whole wait, or its start-up never ends
	sequence seq_waiting;
		st.fsm == osc_switch_pkg::ST_WAIT;
	endsequence

	AST_DISABLED_NO_REQUEST: assert property (!sw_en |=> !st.switch_request_bit) // R3
		else $error("switch request set while switching disabled");

	AST_DISABLED_STATUS: assert property (!sw_en && st.init_done |->
		ctrl_view[`CTRL_CURRENT_SOURCE_STATUS_MSB:`CTRL_CURRENT_SOURCE_STATUS_LSB] == st.s2.init_src
		##1 sys_clk_select_o == $past(st.s2.init_src)) // R2
		else $error("disabled status does not follow initial-source fuse");

	AST_REDUNDANT_ABORT: assert property (st.fsm == osc_switch_pkg::ST_CHECK &&
		st.new_source_select == st.current_source_status && !soft_rst_i |=>
		st.fsm == osc_switch_pkg::ST_IDLE && !st.switch_request_bit && st.irq_stat[`IRQ_ABORT]) // R5
		else $error("redundant switch not aborted");

	AST_START_CLEARS: assert property (seq_valid_start |=>
		!st.lock && (!st.cf || $past(st.s2.fail && !st.fail_d))) // R6
		else $error("lock or fail flag not cleared at switch start");

	AST_WAIT_LOCK: assert property (st.fsm == osc_switch_pkg::ST_WAIT &&
		uses_pll(st.target) && !st.lock |=> st.fsm != osc_switch_pkg::ST_COUNT) // R8
		else $error("multiplier target left wait without lock");

	AST_WAIT_OST: assert property (st.fsm == osc_switch_pkg::ST_WAIT &&
		is_crystal(st.target, st.s2.submode) && !st.s2.oscillator_startup_timer |=>
		st.fsm != osc_switch_pkg::ST_COUNT) // R7
		else $error("crystal target left wait before start-up timer");

	AST_TEN_EDGES: assert property (seq_swap |-> st.edge_cnt == `SETTLE_EDGES) // R9
		else $error("swap without ten target clock edges");

	AST_SWAP_RESULT: assert property (seq_swap |=>
		st.current_source_status == $past(st.target) && !st.switch_request_bit &&
		sys_clk_select_o == $past(st.target) && st.irq_stat[`IRQ_DONE]) // R10
		else $error("completion did not update status");

	AST_OLD_SOURCE_OFF: assert property (seq_swap ##1 st.fsm == osc_switch_pkg::ST_IDLE |->
		st.osc_en[`OSC_IDX_SEC] == (st.secondary_osc_enable || st.clk_sel == `SRC_SEC) &&
		st.osc_en[`OSC_IDX_LOW_POWER_RC_OSC] == (keep_low_power_rc_osc || st.clk_sel == `SRC_LOW_POWER_RC_OSC)) // R11
		else $error("old source power not handled after swap");

	AST_LOCKED_WRITE: assert property (acc && avs_i.write &&
		avs_i.address == `OFS_CTRL && !st.win_open |=>
		$stable(st.new_source_select) && $stable(st.secondary_osc_enable)) // R19
		else $error("control write took effect without unlock");

	AST_ONE_WAIT: assert property (req && avs_waitrequest_o ##1 req |-> !avs_waitrequest_o) // R18
		else $error("bus wait longer than one cycle");

	AST_TARGET_POWERED: assert property (seq_waiting |-> // R7
		(osc_enable_o & src_mask(st.target)) == src_mask(st.target) &&
		(multiplier_enable_o || !uses_pll(st.target)))
		else $error("target oscillator not powered while waiting");

	AST_LOCK_NEEDS_MULT: assert property (!st.pll_en |=> !st.lock) // R8
		else $error("lock status set with multiplier off");

	AST_REQUEST_HELD: assert property (switch_busy_o && sw_en |-> // R16
		ctrl_view[`CTRL_SWITCH_REQUEST_BIT_BIT])
		else $error("request bit dropped before the switch ended");

endmodule : system_clock_switch_controller

// ===== test_system_clock_switch_controller.sv
`timescale 1ns/10ps
`include "osc_switch_defs.svh"
module test_system_clock_switch_controller;
	logic mclk_i, rst_i, soft_rst_i, fuse_dis, oscillator_startup_timer, lock, tclk, cfail, wdog;
	logic [2:0] init_src;
	osc_switch_pkg::avs_req_t avs;
	logic [31:0] rdata;
	logic wait_req, mult_en, busy, irq;
	logic [3:0] osc_en;
	logic [2:0] sel;
	logic [1:0] sub_o;
	logic [31:0] q;
	int fails, checks_done;

	system_clock_switch_controller dut (
		.mclk_i(mclk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i), .avs_i(avs),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
		.clock_switch_enable_fuse_i(fuse_dis), .initial_source_fuse_i(init_src),
		.primary_submode_fuse_i(`SUB_XT), .watchdog_enable_i(wdog), .ost_expired_i(oscillator_startup_timer),
		.pll_lock_i(lock), .target_clk_i(tclk), .clock_fail_i(cfail), .osc_enable_o(osc_en),
		.multiplier_enable_o(mult_en), .sys_clk_select_o(sel), .primary_submode_o(sub_o),
		.switch_busy_o(busy), .irq_o(irq)
	);

	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task ticks(input int n);
		repeat (n) @(posedge mclk_i);
	endtask : ticks

	// the request stands until the rising edge at which waitrequest is sampled low
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge mclk_i);
		avs <= '{~wr, wr, a, d, be};
		do begin
			@(posedge mclk_i);
		end while (wait_req !== 1'b0);
		q = rdata;
		avs <= '{1'b0, 1'b0, a, d, be};
	endtask : bus

	task wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
		bus(1'b1, a, d, be);
	endtask : wr

	task rd(input logic [4:0] a);
		bus(1'b0, a, 32'h0, 4'hF);
	endtask : rd

	task unlock;
		wr(`OFS_UNLOCK, {24'h0, `UNLOCK_KEY1}, 4'h1);
		wr(`OFS_UNLOCK, {24'h0, `UNLOCK_KEY2}, 4'h1);
	endtask : unlock

	task set_new_source_select(input logic [2:0] s);
		unlock();
		wr(`OFS_CTRL, {21'h0, s, 8'h00}, 4'h2);
	endtask : set_new_source_select

	task go(input logic lpos);
		unlock();
		wr(`OFS_CTRL, {30'h0, lpos, 1'b1}, 4'h1);
	endtask : go

	// slow source clock: well under half the system clock so the synchroniser sees every edge
	task edges(input int n);
		repeat (n) begin
			ticks(1);
			tclk <= 1'b1;
			ticks(3);
			tclk <= 1'b0;
			ticks(2);
		end
	endtask : edges

	task wait_idle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 300) begin
			@(negedge mclk_i);
			n++;
		end
		chk({31'h0, busy}, 32'h0, "switch never finished");
	endtask : wait_idle

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_reset;
		rd(`OFS_CTRL);
		chk({29'h0, q[14:12]}, {29'h0, `SRC_FRC}, "current source after reset");
		chk({29'h0, q[10:8]}, {29'h0, `SRC_FRC}, "new source after reset");
		chk({31'h0, q[0]}, 32'h0, "request bit after reset");
		rd(5'h14);
		chk(q, 32'h0, "unmapped read");
		rd(`OFS_IRQ_CLR);
		chk(q, 32'h0, "clear register read");
		$display("test reset done");
	endtask : t_reset

	task t_guard;
		wr(`OFS_CTRL, {21'h0, `SRC_PRI, 8'h00}, 4'h2);
		rd(`OFS_CTRL);
		chk({29'h0, q[10:8]}, {29'h0, `SRC_FRC}, "write without unlock");
		wr(`OFS_UNLOCK, {24'h0, `UNLOCK_KEY2}, 4'h1);
		wr(`OFS_UNLOCK, {24'h0, `UNLOCK_KEY1}, 4'h1);
		wr(`OFS_CTRL, {21'h0, `SRC_PRI, 8'h00}, 4'h2);
		rd(`OFS_CTRL);
		chk({29'h0, q[10:8]}, {29'h0, `SRC_FRC}, "keys in wrong order");
		set_new_source_select(`SRC_PRI);
		rd(`OFS_CTRL);
		chk({29'h0, q[10:8]}, {29'h0, `SRC_PRI}, "unlocked upper byte write");
		wr(`OFS_CTRL, {21'h0, `SRC_SEC, 8'h00}, 4'h2);
		rd(`OFS_CTRL);
		chk({29'h0, q[10:8]}, {29'h0, `SRC_PRI}, "window used twice");
		set_new_source_select(`SRC_FRC);
		$display("test guard done");
	endtask : t_guard

	task t_redundant;
		go(1'b0);
		ticks(4);
		rd(`OFS_CTRL);
		chk({31'h0, q[0]}, 32'h0, "redundant request not cleared");
		chk({29'h0, q[14:12]}, {29'h0, `SRC_FRC}, "redundant changed source");
		chk({29'h0, sel}, {29'h0, `SRC_FRC}, "redundant moved clock");
		rd(`OFS_IRQ_STAT);
		chk(q, 32'h2, "abort status");
		chk({31'h0, irq}, 32'h0, "masked interrupt");
		wr(`OFS_IRQ_EN, 32'h7, 4'hF);
		@(negedge mclk_i);
		chk({31'h0, irq}, 32'h1, "enabled interrupt");
		wr(`OFS_IRQ_CLR, 32'h2, 4'hF);
		@(negedge mclk_i);
		chk({31'h0, irq}, 32'h0, "interrupt after clear");
		$display("test redundant done");
	endtask : t_redundant

	task t_pll;
		ticks(1);
		cfail <= 1'b1;
		ticks(6);
		rd(`OFS_CTRL);
		chk({31'h0, q[3]}, 32'h1, "clock fail flag");
		set_new_source_select(`SRC_FRC_PLL);
		go(1'b0);
		ticks(10);
		@(negedge mclk_i);
		chk({31'h0, busy}, 32'h1, "no wait for lock");
		chk({29'h0, sel}, {29'h0, `SRC_FRC}, "clock moved before lock");
		chk({31'h0, mult_en}, 32'h1, "multiplier not powered for target");
		rd(`OFS_CTRL);
		chk({30'h0, q[5], q[3]}, 32'h0, "lock and fail not cleared");
		chk({31'h0, q[0]}, 32'h1, "request bit during switch");
		ticks(1);
		lock <= 1'b1;
		cfail <= 1'b0;
		ticks(8);
		edges(9);
		@(negedge mclk_i);
		chk({31'h0, busy}, 32'h1, "switched after nine edges");
		chk({29'h0, sel}, {29'h0, `SRC_FRC}, "clock moved early");
		edges(1);
		wait_idle();
		chk({29'h0, sel}, {29'h0, `SRC_FRC_PLL}, "clock select after switch");
		rd(`OFS_CTRL);
		chk({29'h0, q[14:12]}, {29'h0, `SRC_FRC_PLL}, "current source copy");
		chk({30'h0, q[5], q[0]}, 32'h2, "lock set and request cleared");
		rd(`OFS_IRQ_STAT);
		chk(q & 32'h1, 32'h1, "done status");
		wr(`OFS_IRQ_CLR, 32'h7, 4'hF);
		$display("test multiplier switch done");
	endtask : t_pll

	task t_crystal;
		set_new_source_select(`SRC_PRI);
		go(1'b1);
		ticks(10);
		@(negedge mclk_i);
		chk({31'h0, busy}, 32'h1, "no wait for start-up timer");
		chk({31'h0, osc_en[0]}, 32'h1, "target not started");
		chk({29'h0, sel}, {29'h0, `SRC_FRC_PLL}, "clock moved before timer");
		ticks(1);
		oscillator_startup_timer <= 1'b1;
		ticks(8);
		edges(10);
		wait_idle();
		chk({29'h0, sel}, {29'h0, `SRC_PRI}, "clock select primary");
		chk({30'h0, osc_en[2], mult_en}, 32'h0, "old source left running");
		chk({30'h0, osc_en[1], osc_en[0]}, 32'h3, "secondary or primary off");
		chk({30'h0, sub_o}, {30'h0, `SUB_XT}, "primary submode");
		$display("test crystal switch done");
	endtask : t_crystal

	task t_soft;
		ticks(1);
		soft_rst_i <= 1'b1;
		ticks(1);
		soft_rst_i <= 1'b0;
		ticks(2);
		rd(`OFS_CTRL);
		chk({29'h0, q[14:12]}, {29'h0, `SRC_PRI}, "source lost on soft reset");
		chk({31'h0, q[1]}, 32'h1, "secondary enable lost on soft reset");
		$display("test soft reset done");
	endtask : t_soft

	task t_disabled;
		ticks(1);
		fuse_dis <= 1'b1;
		init_src <= `SRC_SEC;
		rst_i <= 1'b1;
		ticks(5);
		rst_i <= 1'b0;
		ticks(8);
		rd(`OFS_CTRL);
		chk({29'h0, q[14:12]}, {29'h0, `SRC_SEC}, "status ignores fuse");
		set_new_source_select(`SRC_PRI);
		go(1'b0);
		ticks(20);
		@(negedge mclk_i);
		chk({31'h0, busy}, 32'h0, "switch while disabled");
		chk({29'h0, sel}, {29'h0, `SRC_SEC}, "new source used while disabled");
		chk({31'h0, osc_en[3]}, 32'h0, "low-power rc kept with monitor off");
		rd(`OFS_CTRL);
		chk({31'h0, q[0]}, 32'h0, "request bit while disabled");
		chk({29'h0, q[14:12]}, {29'h0, `SRC_SEC}, "status changed while disabled");
		wdog <= 1'b1;
		ticks(1);
		@(negedge mclk_i);
		chk({31'h0, osc_en[3]}, 32'h1, "low-power rc stopped under watchdog");
		$display("test disabled done");
	endtask : t_disabled

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		rst_i = 1'b1;
		soft_rst_i = 1'b0;
		avs = '0;
		fuse_dis = 1'b0;
		init_src = `SRC_FRC;
		oscillator_startup_timer = 1'b0;
		lock = 1'b0;
		tclk = 1'b0;
		cfail = 1'b0;
		wdog = 1'b0;
		fails = 0;
		checks_done = 0;
		ticks(5);
		rst_i <= 1'b0;
		ticks(8);
		t_reset();
		t_guard();
		t_redundant();
		t_pll();
		t_crystal();
		t_soft();
		t_disabled();
		tally_and_finish();
	end

	// the whole run needs about four hundred cycles
	initial begin
		ticks(6000);
		fails++;
		$display("BAD %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule : test_system_clock_switch_controller
